// ---- rtl/fsc_status_check.sv ----
`timescale 1ns/1ps
module fsc_status_check
    import fsc_pkg::*;
(
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  reset,
    // CPU or programmer bus cycles
    input  wire logic                  busWrite,
    input  wire logic                  busRead,
    input  wire logic                  busExternal,
    input  wire logic [19:0]           busAddr,
    input  wire logic [15:0]           busWdata,
    output logic      [15:0]           busRdata,
    input  wire logic [15:0]           arrayRdata,
    // Flash mode register bits
    input  wire logic                  cpuRewriteModeA,
    input  wire logic                  lockProtectDisable,
    output logic                       readyMirrorBit,
    output logic                       eraseFailMirror,
    output logic                       programFailMirror,
    // Array engine
    output logic                       opStart,
    output fsc_pkg::fsc_op_t           opKind,
    output logic      [19:0]           opAddr,
    output logic                       lockCheckEn,
    input  wire logic                  opDone,
    input  wire logic                  opFail,
    input  wire logic                  blockLocked,
    // Protection and identification
    input  wire logic                  romProtect,
    input  wire logic [ID_BYTES*8-1:0] storedId,
    input  wire logic [7:0]            idRxByte,
    input  wire logic                  idRxValid,
    output logic                       idVerified,
    // Mode pins
    input  wire logic                  bootModePin,
    input  wire logic                  modeSelectPinB,
    input  wire logic                  eraseProgramStrap,
    input  wire logic                  txdPin,
    input  wire logic                  serialClkPin,
    input  wire logic                  bootCheck,
    output logic                       busyPin,
    output logic                       serialClk,
    output logic                       serialMode,
    output logic                       parallelMode,
    output logic                       bootAreaSel
);
    import fsc_pkg::*;

    // ------------------------------------------------------------------
    // Pins and straps
    // ------------------------------------------------------------------
    logic [4:0] pinSync;
    logic [1:0] strapCnt_r;
    logic       serialMode_r;
    logic       parallelMode_r;
    logic       serialModeOne_r;
    logic       busyPin_r;

    fsc_sync #(.WIDTH(5)) u_sync (
        .mclk    (mclk),
        .reset   (reset),
        .pinIn   ({bootModePin, modeSelectPinB, eraseProgramStrap, txdPin, serialClkPin}),
        .pinSync (pinSync)
    );

    // Straps are taken once, after the synchronisers have filled.
    always_ff @(posedge mclk) begin
        if (reset) begin
            strapCnt_r      <= 2'h0;
            serialMode_r    <= 1'b0;
            parallelMode_r  <= 1'b0;
            serialModeOne_r <= 1'b0;
        end else if (strapCnt_r != 2'h3) begin
            strapCnt_r <= strapCnt_r + 2'h1;
            if (strapCnt_r == 2'h2) begin
                serialMode_r    <= pinSync[4] && !pinSync[3] && !pinSync[2];
                parallelMode_r  <= pinSync[4] && !pinSync[3] && pinSync[2];
                serialModeOne_r <= pinSync[1];
            end
        end
    end

    assign serialMode   = serialMode_r;
    assign parallelMode = parallelMode_r;
    assign serialClk    = pinSync[0];

    // ------------------------------------------------------------------
    // Identification check and access gating
    // ------------------------------------------------------------------
    fsc_id_if idIf ();
    assign idIf.rxByte  = idRxByte;
    assign idIf.rxValid = idRxValid;
    assign idIf.restart = !serialMode_r;
    assign idVerified   = idIf.match;

    fsc_id_check u_id (
        .mclk     (mclk),
        .reset    (reset),
        .storedId (storedId),
        .idIf     (idIf)
    );

    logic extBlocked;
    assign extBlocked = busExternal && (romProtect
                        || (serialMode_r && !idIf.match));

    // ------------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------------
    fsc_state_t  state_r, state_nxt;
    fsc_op_t     opKind_r, opKind_nxt;
    logic        ready_r, eraseFail_r, progFail_r, statusMode_r;
    logic        opStart_r;
    logic [19:0] opAddr_r;
    logic        startOp, seqErr, eraseErr, progErr, clearSts;
    logic        stsSet, stsClr;
    logic        wrTake, failAny, lockHit, isConfirm, isArray;
    logic [7:0]  cmd;
    logic [7:0]  statusByte;

    assign cmd       = busWdata[7:0];
    assign wrTake    = busWrite && !extBlocked && (state_r != ST_BUSY);
    assign failAny   = eraseFail_r || progFail_r;
    assign lockHit   = blockLocked && !lockProtectDisable;
    assign isConfirm = cmd == CMD_CONFIRM;
    assign isArray   = cmd == CMD_READ_ARRAY;

    always_comb begin
        state_nxt  = state_r;
        opKind_nxt = opKind_r;
        startOp    = 1'b0;
        seqErr     = 1'b0;
        eraseErr   = 1'b0;
        progErr    = 1'b0;
        clearSts   = 1'b0;
        stsSet     = 1'b0;
        stsClr     = 1'b0;
        case (state_r)
            ST_READY: if (wrTake) begin
                case (cmd)
                    CMD_READ_ARRAY:   stsClr = 1'b1;
                    CMD_READ_STATUS:  stsSet = 1'b1;
                    CMD_CLEAR_STATUS: clearSts = 1'b1;
                    CMD_PROGRAM:      state_nxt = ST_PROG_DATA;
                    CMD_BLOCK_ERASE:  state_nxt = ST_ERASE_CONF;
                    CMD_ERASE_ALL:    state_nxt = ST_ALL_CONF;
                    CMD_LOCK_PROGRAM: state_nxt = ST_LOCK_CONF;
                    CMD_LOCK_READ:    state_nxt = ST_LRD_CONF;
                    default:          seqErr = 1'b1;
                endcase
            end
            ST_PROG_DATA: if (wrTake) begin
                state_nxt  = ST_READY;
                opKind_nxt = OP_PROGRAM;
                if (!failAny) begin
                    progErr = lockHit;
                    startOp = !lockHit;
                end
            end
            ST_ERASE_CONF, ST_ALL_CONF, ST_LOCK_CONF, ST_LRD_CONF: if (wrTake) begin
                state_nxt = ST_READY;
                if (isArray) begin
                    stsClr = 1'b1;
                end else if (!isConfirm) begin
                    seqErr = 1'b1;
                end else if (state_r == ST_LRD_CONF) begin
                    opKind_nxt = OP_LOCK_READ;
                    startOp    = 1'b1;
                end else if (!failAny) begin
                    case (state_r)
                        ST_ERASE_CONF: opKind_nxt = OP_BLOCK_ERASE;
                        ST_ALL_CONF:   opKind_nxt = OP_ERASE_ALL;
                        default:       opKind_nxt = OP_LOCK_PROGRAM;
                    endcase
                    eraseErr = (state_r == ST_ERASE_CONF) && lockHit;
                    startOp  = !eraseErr;
                end
            end
            ST_BUSY: if (opDone) begin
                state_nxt = ST_READY;
                if (opFail) begin
                    eraseErr = (opKind_r == OP_BLOCK_ERASE) || (opKind_r == OP_ERASE_ALL);
                    progErr  = (opKind_r == OP_PROGRAM) || (opKind_r == OP_LOCK_PROGRAM);
                end
            end
            default: state_nxt = ST_READY;
        endcase
        if (startOp) begin
            state_nxt = ST_BUSY;
            stsSet    = opKind_nxt != OP_LOCK_READ;
        end
    end

    // In parallel mode, boot area block erase lands on the base of its one 4 Kbyte block.
    logic inBoot;
    assign inBoot      = parallelMode_r && busAddr >= BOOT_LO && busAddr <= BOOT_HI;
    assign bootAreaSel = inBoot;

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_r      <= ST_READY;
            opKind_r     <= OP_PROGRAM;
            opAddr_r     <= 20'h00000;
            opStart_r    <= 1'b0;
            statusMode_r <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            opKind_r     <= opKind_nxt;
            opStart_r    <= startOp;
            statusMode_r <= stsSet || (statusMode_r && !stsClr);
            if (startOp) begin
                opAddr_r <= (inBoot && opKind_nxt == OP_BLOCK_ERASE)
                            ? (busAddr & BOOT_BLOCK_MASK) : busAddr;
            end
        end
    end

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------
    // A failure that lands with a clear is kept: the set term wins.
    always_ff @(posedge mclk) begin
        if (reset) begin
            ready_r     <= READY_RST;
            eraseFail_r <= ERASE_FAIL_RST;
            progFail_r  <= PROG_FAIL_RST;
        end else begin
            ready_r     <= !startOp && (ready_r || (state_r == ST_BUSY && opDone));
            eraseFail_r <= seqErr || eraseErr || (eraseFail_r && !clearSts);
            progFail_r  <= seqErr || progErr || (progFail_r && !clearSts);
        end
    end

    always_comb begin
        statusByte                = 8'h00;
        statusByte[STS_READY_BIT] = ready_r;
        statusByte[STS_ERASE_BIT] = eraseFail_r;
        statusByte[STS_PROG_BIT]  = progFail_r;
    end

    assign readyMirrorBit    = ready_r;
    assign eraseFailMirror   = eraseFail_r;
    assign programFailMirror = progFail_r;
    assign opStart           = opStart_r;
    assign opKind            = opKind_r;
    assign opAddr            = opAddr_r;
    assign lockCheckEn       = !lockProtectDisable;

    // ------------------------------------------------------------------
    // Read path and busy pin
    // ------------------------------------------------------------------
    logic showStatus;
    assign showStatus = cpuRewriteModeA && statusMode_r && !busAddr[0]
                        && busAddr >= USER_ROM_LO && busAddr <= USER_ROM_HI;

    always_ff @(posedge mclk) begin
        if (reset) begin
            busRdata  <= 16'h0000;
            busyPin_r <= 1'b0;
        end else begin
            if (busRead) begin
                busRdata <= extBlocked ? 16'h0000
                          : showStatus ? {8'h00, statusByte} : arrayRdata;
            end
            busyPin_r <= serialModeOne_r ? !ready_r : bootCheck;
        end
    end

    assign busyPin = busyPin_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    ready_drop_a: assert property (startOp |=> !ready_r ##1 !ready_r)
        else $error("ready flag not low after start");
    ready_rise_a: assert property (state_r == ST_BUSY && opDone |=> ready_r && state_r == ST_READY)
        else $error("ready flag not set at operation end");
    fail_reject_a: assert property (failAny && state_r == ST_PROG_DATA && wrTake
                                    |=> !opStart_r [*2])
        else $error("command started with a failure flag set");
    seq_error_a: assert property (state_r == ST_ERASE_CONF && wrTake && !isConfirm && !isArray
                                  |=> eraseFail_r && progFail_r)
        else $error("sequence error did not set both flags");
    clear_flags_a: assert property (state_r == ST_READY && wrTake && cmd == CMD_CLEAR_STATUS
                                    |=> !eraseFailMirror && !programFailMirror)
        else $error("clear status left a flag set");
    locked_erase_a: assert property (state_r == ST_ERASE_CONF && wrTake && isConfirm
                                     && !failAny && blockLocked && !lockProtectDisable
                                     |=> eraseFail_r && !progFail_r && !opStart_r)
        else $error("locked erase did not raise erase error");
    lock_bypass_a: assert property (state_r == ST_ERASE_CONF && wrTake && isConfirm
                                    && !failAny && lockProtectDisable
                                    |=> opStart_r && !eraseFail_r)
        else $error("disabled lock check still blocked erase");
    array_exit_a: assert property (state_r == ST_LOCK_CONF && wrTake && isArray
                                   |=> state_r == ST_READY && !statusMode_r && !opStart_r)
        else $error("read array in second cycle not honoured");
    status_read_a: assert property (busRead && showStatus && !extBlocked
                                    |=> busRdata == {8'h00, $past(statusByte)}
                                        && busRdata[6] == 1'b0 && busRdata[3:0] == 4'h0)
        else $error("status byte not returned");
    prog_fail_a: assert property (state_r == ST_BUSY && opDone && opFail && opKind_r == OP_PROGRAM
                                  |=> progFail_r && $stable(eraseFail_r))
        else $error("program failure not flagged");
    protect_read_a: assert property (busRead && busExternal && romProtect
                                     |=> busRdata == 16'h0000)
        else $error("protected read leaked data");

    erase_done_c: cover property (startOp && opKind_nxt == OP_BLOCK_ERASE ##[1:50] opDone);
    seq_error_c:  cover property (seqErr);
    status_c:     cover property (busRead && showStatus);
    clear_c:      cover property (failAny ##[1:20] clearSts);
endmodule // fsc_status_check

// ---- rtl/fsc_pkg.sv ----
package fsc_pkg;

    // ------------------------------------------------------------------
    // Command codes (low byte of the bus write)
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
    localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_PROGRAM      = 8'h40;
    localparam logic [7:0] CMD_BLOCK_ERASE  = 8'h20;
    localparam logic [7:0] CMD_ERASE_ALL    = 8'hA7;
    localparam logic [7:0] CMD_LOCK_PROGRAM = 8'h77;
    localparam logic [7:0] CMD_LOCK_READ    = 8'h71;
    localparam logic [7:0] CMD_CONFIRM      = 8'hD0;

    // ------------------------------------------------------------------
    // Status byte layout and reset values
    // ------------------------------------------------------------------
    localparam int         STS_READY_BIT  = 7;
    localparam int         STS_ERASE_BIT  = 5;
    localparam int         STS_PROG_BIT   = 4;
    localparam logic       READY_RST      = 1'b1;
    localparam logic       ERASE_FAIL_RST = 1'b0;
    localparam logic       PROG_FAIL_RST  = 1'b0;

    // ------------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------------
    localparam int          ADDR_W          = 20;
    localparam logic [19:0] USER_ROM_LO     = 20'hE0000;
    localparam logic [19:0] USER_ROM_HI     = 20'hFFFFF;
    localparam logic [19:0] BOOT_LO         = 20'hFF000;
    localparam logic [19:0] BOOT_HI         = 20'hFFFFF;
    localparam int          BOOT_BLOCK_BYTES = 4096;
    localparam logic [19:0] BOOT_BLOCK_MASK = ~20'(BOOT_BLOCK_BYTES - 1);

    // ------------------------------------------------------------------
    // Identification check
    // ------------------------------------------------------------------
    localparam int ID_BYTES = 7;

    typedef enum {
        ST_READY, ST_PROG_DATA, ST_ERASE_CONF, ST_ALL_CONF,
        ST_LOCK_CONF, ST_LRD_CONF, ST_BUSY
    } fsc_state_t;

    typedef enum logic [2:0] {
        OP_PROGRAM, OP_BLOCK_ERASE, OP_ERASE_ALL, OP_LOCK_PROGRAM, OP_LOCK_READ
    } fsc_op_t;

endpackage

// ---- rtl/fsc_id_if.sv ----
`timescale 1ns/1ps
interface fsc_id_if;
    logic [7:0] rxByte;
    logic       rxValid;
    logic       restart;
    logic       match;
    modport checker_side (input rxByte, input rxValid, input restart, output match);
    modport user_side    (output rxByte, output rxValid, output restart, input match);
endinterface

// ---- rtl/fsc_sync.sv ----
`timescale 1ns/1ps
module fsc_sync #(
    parameter int WIDTH = 5
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             reset,
    // Pins in, synchronised out
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinSync
);
    logic [WIDTH-1:0] stage1_r;

    always_ff @(posedge mclk) begin
        if (reset) begin
            stage1_r <= '0;
            pinSync  <= '0;
        end else begin
            stage1_r <= pinIn;
            pinSync  <= stage1_r;
        end
    end
endmodule // fsc_sync

// ---- rtl/fsc_id_check.sv ----
`timescale 1ns/1ps
module fsc_id_check
    import fsc_pkg::*;
(
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  reset,
    // Codes stored in flash, first byte lowest
    input  wire logic [ID_BYTES*8-1:0] storedId,
    // Received bytes
    fsc_id_if.checker_side             idIf
);
    logic [2:0] index_r;
    logic       allEq_r;
    logic       match_r;
    logic [7:0] expected;

    assign expected   = storedId[8*index_r +: 8];
    assign idIf.match = match_r;

    // Only reset or restart returns the index to the first byte, so after a failed
    // attempt the match stays low until one of them comes.
    always_ff @(posedge mclk) begin
        if (reset || idIf.restart) begin
            index_r <= 3'h0;
            allEq_r <= 1'b1;
            match_r <= 1'b0;
        end else if (idIf.rxValid && index_r < 3'(ID_BYTES)) begin
            index_r <= index_r + 3'h1;
            allEq_r <= allEq_r && (idIf.rxByte == expected);
            match_r <= (index_r == 3'(ID_BYTES - 1)) && allEq_r
                       && (idIf.rxByte == expected);
        end
    end
endmodule // fsc_id_check

// ---- bench/fsc_engine_model.sv ----
`timescale 1ns/1ps
module fsc_engine_model #(
    parameter int LAT = 6
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic reset,
    // Start and result
    input  wire logic opStart,
    input  wire logic failNext,
    output logic      opDone,
    output logic      opFail
);
    int cnt;
    // ------------------------------------------------------------------
    // Done pulse a fixed time after each start
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset || opStart) cnt <= reset ? 0 : LAT;
        else if (cnt != 0) cnt <= cnt - 1;
    end
    assign opDone = (cnt == 1);
    // A failure is only flagged with done, as a real engine would.
    assign opFail = opDone & failNext;
endmodule // fsc_engine_model

// ---- bench/flash_status_and_error_check_tb_top.sv ----
`timescale 1ns/1ps
module flash_status_and_error_check_tb_top;
    import fsc_pkg::*;
    logic mclk, reset, busWrite, busRead, busExternal, cpuRewriteModeA, lockProtectDisable;
    logic blockLocked, romProtect, failNext, opDone, opFail, opStart, lockCheckEn, bootAreaSel;
    logic readyMirrorBit, eraseFailMirror, programFailMirror;
    logic bootModePin = 1'b1, modeSelectPinB = 1'b0, eraseProgramStrap = 1'b1, txdPin = 1'b1;
    logic serialClkPin = 1'b0, bootCheck = 1'b1, idRxValid, idVerified, busyPin;
    logic serialClk, serialMode, parallelMode;
    logic [7:0] idRxByte;
    // Arbitrary pattern; any seven bytes serve for the match check.
    logic [ID_BYTES*8-1:0] storedId = 56'h3C5A960FE17B24;
    logic [19:0] busAddr, opAddr;
    logic [15:0] busWdata, busRdata, rdv;
    logic [15:0] arrayRdata = 16'hA5A5;
    fsc_op_t     opKind;
    int          err_total, checked, cycles, starts, s;
    fsc_status_check i_dut (.mclk, .reset, .busWrite, .busRead, .busExternal, .busAddr,
        .busWdata, .busRdata, .arrayRdata, .cpuRewriteModeA, .lockProtectDisable,
        .readyMirrorBit, .eraseFailMirror, .programFailMirror, .opStart, .opKind, .opAddr,
        .lockCheckEn, .opDone, .opFail, .blockLocked, .romProtect, .storedId,
        .idRxByte, .idRxValid, .idVerified, .bootModePin, .modeSelectPinB,
        .eraseProgramStrap, .txdPin, .serialClkPin, .bootCheck, .busyPin,
        .serialClk, .serialMode, .parallelMode, .bootAreaSel);
    fsc_engine_model i_eng (.mclk, .reset, .opStart, .failNext, .opDone, .opFail);
    // ------------------------------------------------------------------
    // Bus cycles and comparison
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic fl(input logic [2:0] e);
        chk({13'h0, readyMirrorBit, eraseFailMirror, programFailMirror}, {13'h0, e});
    endtask
    // The idle cycle after each write keeps strobes from being re-raised in one step.
    task automatic wr(input logic [19:0] a, input logic [15:0] d);
        busAddr = a;
        busWdata = d;
        busWrite = 1'b1;
        @(posedge mclk); #1 busWrite = 1'b0;
        @(posedge mclk); #1;
    endtask
    task automatic rd(input logic [19:0] a);
        busAddr = a;
        busRead = 1'b1;
        @(posedge mclk); #1 busRead = 1'b0;
        rdv = busRdata;
        @(posedge mclk); #1;
    endtask
    task automatic wait_ready;
        for (int i = 0; i < 50 && readyMirrorBit !== 1'b1; i++) begin
            @(posedge mclk); #1;
        end
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        fl(3'b100);
        wr(20'hE0000, 16'h0070);
        rd(20'hE0002); chk(rdv, 16'h0080);
        rd(20'hE0001); chk(rdv, 16'hA5A5);
        wr(20'hE0000, 16'h00FF);
        rd(20'hE0000); chk(rdv, 16'hA5A5);
    endtask
    task automatic t_erase;
        s = starts;
        wr(20'hE0FFE, 16'h0020);
        wr(20'hE0FFE, 16'h00D0);
        fl(3'b000);
        chk(16'(opKind), 16'(OP_BLOCK_ERASE));
        rd(20'hE0000); chk(rdv, 16'h0000);
        wait_ready();
        rd(20'hE0000); chk(rdv, 16'h0080);
        chk(16'(starts), 16'(s + 1));
        wr(20'hE0000, 16'h00FF);
        rd(20'hE0000); chk(rdv, 16'hA5A5);
    endtask
    task automatic t_fail_reject;
        failNext = 1'b1;
        wr(20'hE0100, 16'h0040);
        wr(20'hE0100, 16'h1234);
        wait_ready();
        failNext = 1'b0;
        fl(3'b101);
        rd(20'hE0000); chk(rdv, 16'h0090);
        s = starts;
        wr(20'hE0FFE, 16'h0020);
        wr(20'hE0FFE, 16'h00D0);
        wr(20'hE0100, 16'h0040);
        wr(20'hE0100, 16'h1234);
        chk(16'(starts), 16'(s));
        wr(20'hE0000, 16'h0050);
        fl(3'b100);
        wr(20'hE0FFE, 16'h0020);
        wr(20'hE0FFE, 16'h0055);
        fl(3'b111);
        wr(20'hE0000, 16'h0050);
        s = starts;
        wr(20'hE0FFE, 16'h0077);
        wr(20'hE0FFE, 16'h00FF);
        fl(3'b100);
        chk(16'(starts), 16'(s));
        rd(20'hE0000); chk(rdv, 16'hA5A5);
    endtask
    task automatic t_locked;
        s = starts;
        blockLocked = 1'b1;
        wr(20'hE0FFE, 16'h0020);
        wr(20'hE0FFE, 16'h00D0);
        fl(3'b110);
        wr(20'hE0000, 16'h0050);
        lockProtectDisable = 1'b1;
        wr(20'hE0FFE, 16'h0020);
        chk({15'h0, lockCheckEn}, 16'h0000);
        wr(20'hE0FFE, 16'h00D0);
        wait_ready();
        fl(3'b100);
        chk(16'(starts), 16'(s + 1));
        lockProtectDisable = 1'b0;
        blockLocked = 1'b0;
    endtask
    task automatic t_boot_protect;
        busAddr = 20'hFF000; #1 chk({15'h0, bootAreaSel}, 16'h0001);
        busAddr = 20'hFEFFF; #1 chk({15'h0, bootAreaSel}, 16'h0000);
        wr(20'hFFFFE, 16'h0020);
        wr(20'hFFFFE, 16'h00D0);
        chk(opAddr[15:0], 16'hF000);
        wait_ready();
        busExternal = 1'b1;
        romProtect = 1'b1;
        rd(20'hE0000); chk(rdv, 16'h0000);
        busExternal = 1'b0;
        romProtect = 1'b0;
    endtask
    task automatic t_serial;
        eraseProgramStrap = 1'b0;
        txdPin = 1'b1;
        serialClkPin = 1'b1;
        reset = 1'b1;
        repeat (20) @(posedge mclk);
        #1 reset = 1'b0;
        repeat (5) @(posedge mclk);
        #1;
        fl(3'b100);
        chk({14'h0, serialMode, parallelMode}, 16'h0002);
        chk({14'h0, serialClk, busyPin}, 16'h0002);
        chk({15'h0, idVerified}, 16'h0000);
        busExternal = 1'b1;
        rd(20'hE0000); chk(rdv, 16'h0000);
        idRxValid = 1'b1;
        for (int i = 0; i < ID_BYTES; i++) begin
            idRxByte = storedId[8*i +: 8];
            @(posedge mclk); #1;
        end
        idRxValid = 1'b0;
        chk({15'h0, idVerified}, 16'h0001);
        rd(20'hE0000); chk(rdv, 16'hA5A5);
        busExternal = 1'b0;
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (opStart === 1'b1) starts++;
        if (cycles == 3000) begin
            err_total++;
            complete_run();
        end
    end
    initial begin
        {busWrite, busRead, busExternal, lockProtectDisable, blockLocked} = '0;
        {romProtect, failNext, idRxValid} = '0;
        idRxByte = 8'h00;
        cpuRewriteModeA = 1'b1;
        busAddr = 20'h00000;
        busWdata = 16'h0000;
        reset = 1'b1;
        repeat (3) @(posedge mclk);
        #1 reset = 1'b0;
        repeat (5) @(posedge mclk);
        #1;
        t_reset();
        t_erase();
        t_fail_reject();
        t_locked();
        t_boot_protect();
        t_serial();
        complete_run();
    end
endmodule // flash_status_and_error_check_tb_top
